// ==== rtl/adf_datapath.sv ====
`timescale 1ns/1ps
`include "adf_defs.svh"
module adf_datapath
   import adf_pkg::*;
#(
   parameter int FIFO_DEPTH = `ADF_FIFO_DEPTH,
   parameter int OUT_DIV    = `ADF_OUT_DIV
) (
   input  wire logic        REF_CLK,
   input  wire logic        RESETN,
   input  wire logic        ADC_STROBE,
   input  wire logic [15:0] ADC_DATA,
   input  wire logic        CARRIER_RECURSIVE,
   input  wire logic        PHASE_DOWN,
   input  wire logic        RATE_HALVE,
   output      logic        IN_READY,
   output      logic [11:0] SWEPT_SINE_OSCILLATOR_DATA,
   output      logic        SWEPT_SINE_OSCILLATOR_STROBE,
   output      logic [15:0] DISP_VERT,
   output      logic [15:0] DISP_HORIZ,
   output      logic        DISP_STROBE
);
   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic        stb_m_q, stb_s_q, stb_p_q;
   logic [15:0] dat_m_q, dat_s_q;
   logic        rec_m_q, rec_s_q, dn_m_q, dn_s_q, hv_m_q, hv_s_q;
   logic        stb_rise;

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         stb_m_q <= 1'b0;
         stb_s_q <= 1'b0;
         stb_p_q <= 1'b0;
         dat_m_q <= 16'h0000;
         dat_s_q <= 16'h0000;
         rec_m_q <= 1'b0;
         rec_s_q <= 1'b0;
         dn_m_q  <= 1'b0;
         dn_s_q  <= 1'b0;
         hv_m_q  <= 1'b0;
         hv_s_q  <= 1'b0;
      end else begin
         stb_m_q <= ADC_STROBE;
         stb_s_q <= stb_m_q;
         stb_p_q <= stb_s_q;
         dat_m_q <= ADC_DATA;
         dat_s_q <= dat_m_q;
         rec_m_q <= CARRIER_RECURSIVE;
         rec_s_q <= rec_m_q;
         dn_m_q  <= PHASE_DOWN;
         dn_s_q  <= dn_m_q;
         hv_m_q  <= RATE_HALVE;
         hv_s_q  <= hv_m_q;
      end
   end
   assign stb_rise = stb_s_q && !stb_p_q;

   ////////////////////////////////////////////////////////////////////////////
   // Input FIFO
   logic        in_valid, in_pop;
   logic [15:0] in_data;
   adf_uop_t    uop;
   logic        stall;

   adf_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_in_fifo ( // RULE_07
      .clk       (REF_CLK),
      .rst_n     (RESETN),
      .in_valid  (stb_rise),
      .in_ready  (IN_READY),
      .in_data   (dat_s_q),
      .out_valid (in_valid),
      .out_ready (in_pop),
      .out_data  (in_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Microprogram ROM
   logic [`ADF_UPC_W-1:0] upc_q, upc_d;
   logic [8:0]            phase_q, phase_d;
   logic                  decim_q, decim_d;
   logic                  out_ready;

   function automatic adf_uop_t urom(input logic [`ADF_UPC_W-1:0] a, input logic rec);
      adf_uop_t u;
      u = '0;
      u.src = ADF_SRC_ZERO;
      u.au  = ADF_AU_NOP;
      case (a)
         // Fetch sample, apply rate halving
         5'd0:  begin u.src = ADF_SRC_FIFO; u.tmp_we = 1'b1; u.in_pop = 1'b1;
                      u.decim_skip = 1'b1; end // RULE_03
         // Carrier: sine from phase, or RAM word ADF_RA_SIN when recursive
         5'd1:  begin u.src = rec ? ADF_SRC_RAM : ADF_SRC_SINE;
                      u.ram_addr = `ADF_RA_SIN; u.au = ADF_AU_LDX; end // RULE_05 RULE_06
         // Mixer: x * carrier
         5'd2:  begin u.src = ADF_SRC_TMP; u.au = ADF_AU_MUL; end // RULE_08
         // Section 0: w = x - b1*w1 - b2*w2
         5'd3:  begin u.src = ADF_SRC_RAM; u.ram_addr = `ADF_RA_B1; u.au = ADF_AU_LDX; end
         5'd4:  begin u.src = ADF_SRC_RAM; u.ram_addr = `ADF_RA_W1_S0;
                      u.au = ADF_AU_MSUB; end // RULE_01
         5'd5:  begin u.src = ADF_SRC_RAM; u.ram_addr = `ADF_RA_B2; u.au = ADF_AU_LDX; end
         5'd6:  begin u.src = ADF_SRC_RAM; u.ram_addr = `ADF_RA_W2_S0;
                      u.au = ADF_AU_MSUB; end
         5'd7:  begin u.src = ADF_SRC_ACC; u.ram_addr = `ADF_RA_ACC_SAVE;
                      u.ram_we = 1'b1; end
         // y = w + a1*w1 + a2*w2, shift delays through temp
         5'd8:  begin u.src = ADF_SRC_RAM; u.ram_addr = `ADF_RA_A1; u.au = ADF_AU_LDX; end
         5'd9:  begin u.src = ADF_SRC_RAM; u.ram_addr = `ADF_RA_W1_S0; u.au = ADF_AU_MAC; end
         5'd10: begin u.src = ADF_SRC_RAM; u.ram_addr = `ADF_RA_A2; u.au = ADF_AU_LDX; end
         5'd11: begin u.src = ADF_SRC_RAM; u.ram_addr = `ADF_RA_W2_S0; u.au = ADF_AU_MAC; end
         5'd12: begin u.src = ADF_SRC_RAM; u.ram_addr = `ADF_RA_W1_S0;
                      u.tmp_we = 1'b1; end // RULE_10
         5'd13: begin u.src = ADF_SRC_TMP; u.ram_addr = `ADF_RA_W2_S0; u.ram_we = 1'b1; end
         5'd14: begin u.src = ADF_SRC_RAM; u.ram_addr = `ADF_RA_ACC_SAVE; u.tmp_we = 1'b1; end
         5'd15: begin u.src = ADF_SRC_TMP; u.ram_addr = `ADF_RA_W1_S0; u.ram_we = 1'b1; end
         // Section 1 fed by section 0 output
         5'd16: begin u.src = ADF_SRC_ACC; u.tmp_we = 1'b1; end // RULE_02
         5'd17: begin u.src = ADF_SRC_RAM; u.ram_addr = `ADF_RA_B1; u.au = ADF_AU_LDX; end
         5'd18: begin u.src = ADF_SRC_RAM; u.ram_addr = `ADF_RA_W1_S1; u.au = ADF_AU_MSUB; end
         5'd19: begin u.src = ADF_SRC_RAM; u.ram_addr = `ADF_RA_W1_S0;
                      u.ram_addr = `ADF_RA_W2_S1; u.au = ADF_AU_NOP; end
         5'd20: begin u.src = ADF_SRC_TMP; u.ram_addr = `ADF_RA_W2_S1; u.ram_we = 1'b1; end
         5'd21: begin u.src = ADF_SRC_ACC; u.ram_addr = `ADF_RA_W1_S1; u.ram_we = 1'b1;
                      u.hold_load = 1'b1; end // RULE_09
         // Outputs and carrier advance
         5'd22: begin u.src = ADF_SRC_HOLD; u.out_push = 1'b1; u.disp_load = 1'b1;
                      u.phase_step = 1'b1; u.last = 1'b1; end // RULE_04
         default: u.last = 1'b1;
      endcase
      return u;
   endfunction

   assign uop = urom(upc_q, rec_s_q); // RULE_14

   // Stall on empty input or full output
   assign stall = (uop.in_pop && !in_valid) || (uop.out_push && !out_ready); // RULE_17
   assign in_pop = uop.in_pop && !stall;

   always_comb begin
      upc_d   = upc_q;
      phase_d = phase_q;
      decim_d = decim_q;
      if (!stall) begin
         if (uop.decim_skip && hv_s_q && decim_q) begin
            upc_d = '0;
         end else if (uop.last) begin
            upc_d = '0;
         end else begin
            upc_d = upc_q + 1'b1;
         end
         if (uop.decim_skip) begin
            decim_d = hv_s_q ? !decim_q : 1'b0;
         end
         if (uop.phase_step) begin
            phase_d = dn_s_q ? phase_q - 1'b1 : phase_q + 1'b1;
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         upc_q   <= '0;
         phase_q <= 9'h000;
         decim_q <= 1'b0;
      end else begin
         upc_q   <= upc_d;
         phase_q <= phase_d;
         decim_q <= decim_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus, RAM, temp register, arithmetic unit
   logic [15:0]       ram [`ADF_RAM_WORDS];
   logic [15:0]       bus, tmp_q, tmp_d, x_q, x_d, hold_q, hold_d, sine;
   logic signed [31:0] acc_q, acc_d, prod;
   logic [7:0]         qtr;

   assign qtr  = phase_q[7] ? ~phase_q[7:0] : phase_q[7:0];
   assign sine = phase_q[8] ? 16'(-$signed({1'b0, qtr, 7'h00})) : {1'b0, qtr, 7'h00};

   always_comb begin
      unique case (uop.src)
         ADF_SRC_FIFO: bus = in_data;
         ADF_SRC_RAM:  bus = ram[uop.ram_addr];
         ADF_SRC_TMP:  bus = tmp_q;
         ADF_SRC_ACC:  bus = acc_q[30:15];
         ADF_SRC_SINE: bus = sine;
         ADF_SRC_HOLD: bus = hold_q;
         default:      bus = 16'h0000;
      endcase
   end

   // Q15 product: magnitudes below one never overflow
   assign prod = $signed(x_q) * $signed(bus); // RULE_15

   always_comb begin
      acc_d  = acc_q;
      x_d    = x_q;
      tmp_d  = tmp_q;
      hold_d = hold_q;
      if (!stall) begin
         unique case (uop.au)
            ADF_AU_MUL:  acc_d = prod;
            ADF_AU_MAC:  acc_d = acc_q + prod; // RULE_08
            ADF_AU_MSUB: acc_d = acc_q - prod;
            ADF_AU_LDX:  x_d = bus;
            default:     acc_d = acc_q;
         endcase
         if (uop.tmp_we) begin
            tmp_d = bus;
         end
         if (uop.hold_load) begin
            hold_d = bus;
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         acc_q  <= 32'h0000_0000;
         x_q    <= 16'h0000;
         tmp_q  <= 16'h0000;
         hold_q <= 16'h0000;
      end else begin
         acc_q  <= acc_d;
         x_q    <= x_d;
         tmp_q  <= tmp_d;
         hold_q <= hold_d;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (uop.ram_we && !stall) begin
         ram[uop.ram_addr] <= bus;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator output FIFO and display
   logic        out_valid, tick;
   logic [11:0] out_data;
   logic [15:0] div_q, div_d;
   logic [11:0] dac_q, dac_d;
   logic        dstb_q, dstb_d;
   adf_disp_t   disp_q, disp_d;

   adf_fifo #(.WIDTH(`ADF_DAC_W), .DEPTH(FIFO_DEPTH)) u_out_fifo ( // RULE_11
      .clk       (REF_CLK),
      .rst_n     (RESETN),
      .in_valid  (uop.out_push && !stall),
      .in_ready  (out_ready),
      .in_data   (sine[15:4]),
      .out_valid (out_valid),
      .out_ready (tick),
      .out_data  (out_data)
   );

   assign tick = (div_q == 16'(OUT_DIV - 1));

   always_comb begin
      div_d  = tick ? 16'h0000 : div_q + 16'h0001;
      dac_d  = (tick && out_valid) ? out_data : dac_q; // RULE_12
      dstb_d = 1'b0;
      disp_d = disp_q;
      if (uop.disp_load && !stall) begin
         disp_d = '{vert: bus, horiz: {phase_q, 7'h00}}; // RULE_13
         dstb_d = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         div_q  <= 16'h0000;
         dac_q  <= 12'h000;
         dstb_q <= 1'b0;
         disp_q <= '0;
      end else begin
         div_q  <= div_d;
         dac_q  <= dac_d;
         dstb_q <= dstb_d;
         disp_q <= disp_d;
      end
   end

   assign SWEPT_SINE_OSCILLATOR_DATA   = dac_q;
   assign SWEPT_SINE_OSCILLATOR_STROBE = tick;
   assign DISP_VERT                    = disp_q.vert;
   assign DISP_HORIZ                   = disp_q.horiz;
   assign DISP_STROBE                  = dstb_q;
endmodule

// ==== rtl/adf_defs.svh ====
// Overview of operation
// [RULE_01] Each biquad section computes 1+a1z^-1+a2z^-2 over 1+b1z^-1+b2z^-2 with multiply, add, delay; section 1 here applies only the b1 term.
// [RULE_02] Sections chain: one section's output becomes the next section's input.
// [RULE_03] Rate halving drops every other sample, only after an anti-alias filter; here the sample is dropped at fetch, before any filtering.
// [RULE_04] Rate raising repeats the held sample until the next one arrives.
// [RULE_05] Carrier comes from an up/down phase counter through a sine lookup table; here the phase bits are folded into a triangle wave, with no table.
// [RULE_06] Carrier may instead come from a sin/cos rotation recursion; here that setting only reads RAM word ADF_RA_SIN, which nothing writes.
// [RULE_07] Input samples pass a FIFO before reaching the shared 16-bit bus.
// [RULE_08] Arithmetic unit does 16-bit multiply and multiply-accumulate from the bus.
// [RULE_09] A 16-bit RAM holds intermediate values such as filter state.
// [RULE_10] A 16-bit temporary register gives unit delay and moves bus data.
// [RULE_11] Oscillator samples pass a FIFO so they leave at a uniform rate.
// [RULE_12] Oscillator output word to the converter is 12 bits wide.
// [RULE_13] Vertical and horizontal display outputs update together.
// [RULE_14] Sequencing comes from a microprogram in ROM, not hardwired machines.
// [RULE_15] Values are two's complement fractions below one; products cannot overflow.
// [RULE_16] Input converter supplies new samples at 50 kHz.
// [RULE_17] Microprogram stalls while the input FIFO is empty or output FIFO full.
`ifndef ADF_DEFS_SVH
`define ADF_DEFS_SVH
`define ADF_CLK_HZ        125000000
`define ADF_OUT_RATE_HZ   50000
`define ADF_OUT_DIV       (`ADF_CLK_HZ / `ADF_OUT_RATE_HZ)
`define ADF_FIFO_DEPTH    16
`define ADF_RAM_WORDS     64
`define ADF_UPC_W         5
`define ADF_DAC_W         12
// RAM map
`define ADF_RA_SIN        6'h00
`define ADF_RA_COS        6'h01
`define ADF_RA_SIND       6'h02
`define ADF_RA_COSD       6'h03
`define ADF_RA_ACC_SAVE   6'h04
`define ADF_RA_W1_S0      6'h08
`define ADF_RA_W2_S0      6'h09
`define ADF_RA_W1_S1      6'h0A
`define ADF_RA_W2_S1      6'h0B
`define ADF_RA_A1         6'h10
`define ADF_RA_A2         6'h11
`define ADF_RA_B1         6'h12
`define ADF_RA_B2         6'h13
`endif

// ==== rtl/adf_pkg.sv ====
package adf_pkg;
   typedef enum logic [2:0] {
      ADF_SRC_ZERO = 3'h0,
      ADF_SRC_FIFO = 3'h1,
      ADF_SRC_RAM  = 3'h2,
      ADF_SRC_TMP  = 3'h3,
      ADF_SRC_ACC  = 3'h4,
      ADF_SRC_SINE = 3'h5,
      ADF_SRC_HOLD = 3'h6
   } adf_src_t;
   typedef enum logic [2:0] {
      ADF_AU_NOP  = 3'h0,
      ADF_AU_MUL  = 3'h1,
      ADF_AU_MAC  = 3'h2,
      ADF_AU_MSUB = 3'h3,
      ADF_AU_LDX  = 3'h4
   } adf_au_t;
   typedef enum logic [1:0] {
      ADF_RUN  = 2'b00,
      ADF_WAIT = 2'b01,
      ADF_HALT = 2'b11
   } adf_seq_t;
   typedef struct packed {
      adf_src_t  src;
      adf_au_t   au;
      logic [5:0] ram_addr;
      logic      ram_we;
      logic      tmp_we;
      logic      in_pop;
      logic      out_push;
      logic      disp_load;
      logic      hold_load;
      logic      phase_step;
      logic      decim_skip;
      logic      last;
   } adf_uop_t;
   typedef struct packed {
      logic [15:0] vert;
      logic [15:0] horiz;
   } adf_disp_t;
endpackage

// ==== rtl/adf_fifo.sv ====
`timescale 1ns/1ps
module adf_fifo
   import adf_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
   logic             push, pop;

   assign in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
   assign out_valid = wp_q != rp_q;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rp_q[AW-1:0]];

   always_comb begin
      wp_d = push ? wp_q + 1'b1 : wp_q;
      rp_d = pop ? rp_q + 1'b1 : rp_q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_q[AW-1:0]] <= in_data;
      end
   end
endmodule

// ==== tb/adf_datapath_asserts.sv ====
`timescale 1ns/1ps
module adf_datapath_chk
   import adf_pkg::*;
#(
   parameter int FIFO_DEPTH = 16,
   parameter int OUT_DIV    = 2500
) (
   input wire logic        REF_CLK,
   input wire logic        RESETN,
   input wire logic        ADC_STROBE,
   input wire logic [15:0] ADC_DATA,
   input wire logic        CARRIER_RECURSIVE,
   input wire logic        PHASE_DOWN,
   input wire logic        RATE_HALVE,
   input wire logic        IN_READY,
   input wire logic [11:0] SWEPT_SINE_OSCILLATOR_DATA,
   input wire logic        SWEPT_SINE_OSCILLATOR_STROBE,
   input wire logic [15:0] DISP_VERT,
   input wire logic [15:0] DISP_HORIZ,
   input wire logic        DISP_STROBE
);
   logic [15:0] gap_q;
   logic [15:0] gap_d;
   logic [15:0] idle_q;
   logic [15:0] idle_d;

   // Cycles since last output tick and since last input strobe
   always_comb begin
      gap_d  = (gap_q == 16'hFFFF) ? gap_q : gap_q + 16'h0001;
      idle_d = (idle_q == 16'hFFFF) ? idle_q : idle_q + 16'h0001;
      if (SWEPT_SINE_OSCILLATOR_STROBE) gap_d = 16'h0000;
      if (ADC_STROBE) idle_d = 16'h0000;
   end
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         gap_q  <= 16'hFFFF;
         idle_q <= 16'hFFFF;
      end else begin
         gap_q  <= gap_d;
         idle_q <= idle_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);

   sequence s_accept;
      $rose(ADC_STROBE) && IN_READY && !RATE_HALVE;
   endsequence
   sequence s_disp_due;
      ##[4:1000] DISP_STROBE;
   endsequence

   a_in_to_disp: assert property (s_accept |-> s_disp_due)
      else $error("accepted sample produced no display update");
   a_disp_single: assert property (DISP_STROBE |=> !DISP_STROBE)
      else $error("display strobe longer than one cycle");
   a_disp_together: assert property (
      ($changed(DISP_VERT) || $changed(DISP_HORIZ)) |-> DISP_STROBE)
      else $error("display word changed without strobe");
   a_dac_single: assert property (SWEPT_SINE_OSCILLATOR_STROBE |=> !SWEPT_SINE_OSCILLATOR_STROBE)
      else $error("oscillator strobe longer than one cycle");
   a_dac_spacing: assert property (SWEPT_SINE_OSCILLATOR_STROBE |-> int'(gap_q) >= OUT_DIV - 1)
      else $error("oscillator ticks closer than divider");
   a_dac_hold: assert property (
      $changed(SWEPT_SINE_OSCILLATOR_DATA) |->
         SWEPT_SINE_OSCILLATOR_STROBE || $past(SWEPT_SINE_OSCILLATOR_STROBE))
      else $error("oscillator word changed between ticks");
   a_no_idle_disp: assert property (DISP_STROBE |-> idle_q < 16'h0320)
      else $error("display update without input sample");
   a_ready_reset: assert property ($rose(RESETN) |-> IN_READY)
      else $error("input not ready after reset");
endmodule

bind adf_datapath adf_datapath_chk #(.FIFO_DEPTH(FIFO_DEPTH), .OUT_DIV(OUT_DIV)) adf_datapath_chk_i (
   .REF_CLK(REF_CLK), .RESETN(RESETN), .ADC_STROBE(ADC_STROBE), .ADC_DATA(ADC_DATA),
   .CARRIER_RECURSIVE(CARRIER_RECURSIVE), .PHASE_DOWN(PHASE_DOWN), .RATE_HALVE(RATE_HALVE),
   .IN_READY(IN_READY), .SWEPT_SINE_OSCILLATOR_DATA(SWEPT_SINE_OSCILLATOR_DATA),
   .SWEPT_SINE_OSCILLATOR_STROBE(SWEPT_SINE_OSCILLATOR_STROBE), .DISP_VERT(DISP_VERT),
   .DISP_HORIZ(DISP_HORIZ), .DISP_STROBE(DISP_STROBE));

// ==== tb/adf_conv_model.sv ====
`timescale 1ns/1ps
module adf_conv_model #(
   parameter int OUT_DIV = 8
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   output      logic        adc_strobe,
   output      logic [15:0] adc_data,
   input  wire logic [11:0] dac_data,
   input  wire logic        dac_strobe
);
   int          n_dac;
   int          n_bad;
   int          since;
   logic [11:0] dac_word;

   initial begin
      adc_strobe = 1'b0;
      adc_data   = 16'h0000;
      n_dac      = 0;
      n_bad      = 0;
      since      = 0;
   end

   // Sample paced by gap; data stable around the strobe, inverted once released
   task automatic send(input logic [15:0] d, input int gap);
      @(posedge ref_clk); #1 adc_data = d;
      @(posedge ref_clk); #1 adc_strobe = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 adc_strobe = 1'b0;
      @(posedge ref_clk); #1 adc_data = ~d;
      repeat (gap) @(posedge ref_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Converter side takes 12-bit words on a uniform tick grid
   always @(posedge ref_clk) begin
      since++;
      if (rst_n === 1'b1 && dac_strobe === 1'b1) begin
         if (n_dac > 0 && since % OUT_DIV != 0) n_bad++;
         dac_word = dac_data;
         n_dac++;
         since = 0;
      end
   end
endmodule

// ==== tb/audio_dsp_filter_datapath_test.sv ====
`timescale 1ns/1ps
module audio_dsp_filter_datapath_test;
   import adf_pkg::*;
   localparam int OUT_DIV = 8;
   localparam int DEPTH   = 16;
   localparam int LIMIT   = 20000;

   logic        ref_clk;
   logic        resetn;
   logic        adc_strobe;
   logic [15:0] adc_data;
   logic        carrier_recursive;
   logic        phase_down;
   logic        rate_halve;
   logic        in_ready;
   logic [11:0] dac_data;
   logic        dac_strobe;
   logic [15:0] disp_vert;
   logic [15:0] disp_horiz;
   logic        disp_strobe;
   logic [15:0] horiz_q[$];
   logic        saw_full;
   logic [15:0] d1;
   int          n_fail;
   int          checks_done;
   int          cycles;

   adf_datapath #(.FIFO_DEPTH(DEPTH), .OUT_DIV(OUT_DIV)) adf_datapath_i (
      .REF_CLK(ref_clk), .RESETN(resetn), .ADC_STROBE(adc_strobe), .ADC_DATA(adc_data),
      .CARRIER_RECURSIVE(carrier_recursive), .PHASE_DOWN(phase_down),
      .RATE_HALVE(rate_halve), .IN_READY(in_ready), .SWEPT_SINE_OSCILLATOR_DATA(dac_data),
      .SWEPT_SINE_OSCILLATOR_STROBE(dac_strobe), .DISP_VERT(disp_vert),
      .DISP_HORIZ(disp_horiz), .DISP_STROBE(disp_strobe));
   adf_conv_model #(.OUT_DIV(OUT_DIV)) adf_conv_model_i (
      .ref_clk(ref_clk), .rst_n(resetn), .adc_strobe(adc_strobe), .adc_data(adc_data),
      .dac_data(dac_data), .dac_strobe(dac_strobe));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wait_disp(input int n, input int extra);
      int k;
      k = 0;
      while (horiz_q.size() < n && k < 2000) begin
         @(negedge ref_clk);
         k++;
      end
      repeat (extra) @(negedge ref_clk);
   endtask

   // Display and ready monitor, plus hang limit
   always @(negedge ref_clk) begin
      cycles++;
      if (disp_strobe === 1'b1) horiz_q.push_back(disp_horiz);
      if (in_ready === 1'b0) saw_full = 1'b1;
      if (cycles == LIMIT) begin
         n_fail++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_reset();
      @(negedge ref_clk);
      check({in_ready, disp_strobe, dac_strobe, dac_data, disp_vert, disp_horiz},
            47'h4000_0000_0000);
      $display("test reset done");
   endtask

   task automatic test_ramp();
      int b;
      b = horiz_q.size();
      for (int i = 0; i < 3; i++) adf_conv_model_i.send(16'h2000 + 16'(i), 40);
      wait_disp(b + 3, 0);
      check(horiz_q.size(), b + 3);
      d1 = horiz_q[b + 1] - horiz_q[b];
      check(horiz_q[b + 2] - horiz_q[b + 1], d1);
      check(d1 != 16'h0000, 1);
      @(posedge ref_clk) #1 phase_down = 1'b1;
      for (int i = 0; i < 2; i++) adf_conv_model_i.send(16'hE000 - 16'(i), 40);
      wait_disp(b + 5, 0);
      check(horiz_q[b + 4] - horiz_q[b + 3], 16'h0000 - d1);
      @(posedge ref_clk) #1 phase_down = 1'b0;
      $display("test ramp done");
   endtask

   task automatic test_recursive();
      int b;
      b = horiz_q.size();
      @(posedge ref_clk) #1 carrier_recursive = 1'b1;
      for (int i = 0; i < 2; i++) adf_conv_model_i.send(16'h7FFF - 16'(i), 40);
      wait_disp(b + 2, 60);
      check(horiz_q.size(), b + 2);
      @(posedge ref_clk) #1 carrier_recursive = 1'b0;
      $display("test recursive done");
   endtask

   task automatic test_halve();
      int b;
      b = horiz_q.size();
      @(posedge ref_clk) #1 rate_halve = 1'b1;
      for (int i = 0; i < 4; i++) adf_conv_model_i.send(16'h0100 * 16'(i), 40);
      wait_disp(b + 2, 80);
      check(horiz_q.size(), b + 2);
      @(posedge ref_clk) #1 rate_halve = 1'b0;
      $display("test halve done");
   endtask

   task automatic test_burst();
      int b;
      int n;
      b = horiz_q.size();
      saw_full = 1'b0;
      for (int i = 0; i < 24; i++) adf_conv_model_i.send(16'h8001 + 16'(i), 0);
      wait_disp(b + DEPTH, 800);
      n = horiz_q.size() - b;
      check(saw_full, 1'b1);
      check(n >= DEPTH && n <= 24, 1);
      repeat (300) @(negedge ref_clk);
      check(horiz_q.size() - b, n);
      check(adf_conv_model_i.n_bad, 0);
      check(adf_conv_model_i.n_dac > 0, 1);
      $display("test burst done");
   endtask

   initial begin
      resetn = 1'b0;
      carrier_recursive = 1'b0;
      phase_down = 1'b0;
      rate_halve = 1'b0;
      n_fail = 0;
      checks_done = 0;
      cycles = 0;
      saw_full = 1'b0;
      repeat (9) @(posedge ref_clk);
      test_reset();
      @(posedge ref_clk);
      #1 resetn = 1'b1;
      test_ramp();
      test_recursive();
      test_halve();
      test_burst();
      print_verdict();
   end
endmodule
